// ===== common/link_regs_pkg.sv
// Register map, field layout and reset values of the switch link control block.
//
// Summary of operation
// R1: Debug origin register records which core raised the last chip-wide debug event.
// R2: Link state reports a two-bit source kind: switch, core, control target, undefined.
// R3: Link state shows the eight-bit destination link number while in use.
// R4: External link state holds a writable four-bit direction, cleared at reset.
// R5: External and core link state hold a writable two-bit network number, reset zero.
// R6: A read-only flag shows the current packet is junk; it is discarded.
// R7: Two read-only flags show destination side and source side in use.
// R8: Eight core link registers carry the same fields except direction.
// R9: Setup top bit enables or disables the external link and its pin muxing.
// R10: Setup bit selects two-wire (zero) or five-wire (one) link width.
// R11: Read-only error flag sets on receive overflow or illegal token encoding.
// R12: Read-only bit shows this end has issued credit to the remote end.
// R13: Read-only bit shows this end holds transmit credit; no transmit without it.
// R14: Writing one clears transmit credit and sends a greeting token.
// R15: Writing one restarts the receiver so the next symbol starts a token.
// R16: Eleven-bit field sets least idle clocks between symbols in a token, minus one.
// R17: Eleven-bit field sets least idle clocks between tokens, minus one.
// R18: With fixed forwarding on, all link traffic goes to one channel end, unrouted.
// R19: Fixed forwarding picks destination core by one bit, channel end by five.
// R20: Eight fixed forwarding registers map to links C, D, A, B, G, H, E, F.
// R21: Mismatching packets route by direction of most significant mismatching id bit.
// R22: Write-only credit-clear and receiver-restart bits ignore zero and read as zero.
// R23: Reserved bits read as zero and ignore writes; the code stores and reads back debug bit 4 and bits 1:0 of words 0x10 and 0x11.
`default_nettype none
package link_regs_pkg;

  // ==========================================================================
  // Register word indices; the byte address is four times the index.
  localparam logic [7:0] IDX_RESV_A     = 8'h10;
  localparam logic [7:0] IDX_RESV_B     = 8'h11;
  localparam logic [7:0] IDX_DEBUG      = 8'h1F;
  localparam logic [7:0] IDX_EXT_STATE  = 8'h20;
  localparam logic [7:0] IDX_CORE_STATE = 8'h40;
  localparam logic [7:0] IDX_EXT_SETUP  = 8'h80;
  localparam logic [7:0] IDX_FWD_SETUP  = 8'hA0;

  // ==========================================================================
  // Bus geometry.
  localparam int ADDR_W   = 10;
  localparam int WORD_LSB = 2;

  // ==========================================================================
  // Link state fields.
  localparam int SRC_KIND_LSB = 24;
  localparam int DEST_LSB     = 16;
  localparam int DIR_LSB      = 8;
  localparam int NET_LSB      = 4;
  localparam int JUNK_BIT     = 2;
  localparam int DBUSY_BIT    = 1;
  localparam int SBUSY_BIT    = 0;

  // ==========================================================================
  // Link setup fields.
  localparam int EN_BIT       = 31;
  localparam int WIDE_BIT     = 30;
  localparam int ERR_BIT      = 27;
  localparam int ISSUED_BIT   = 26;
  localparam int CREDIT_BIT   = 25;
  localparam int LINK_GREETING_TOKEN_BIT    = 24;
  localparam int RXRST_BIT    = 23;
  localparam int SYM_GAP_LSB  = 11;
  localparam int TOK_GAP_LSB  = 0;
  localparam int GAP_W        = 11;

  // ==========================================================================
  // Fixed forwarding, debug origin and reserved register fields.
  localparam int FWD_EN_BIT   = 31;
  localparam int FWD_CORE_BIT = 8;
  localparam int FWD_CH_LSB   = 0;
  localparam int DBG_RESV_BIT = 4;
  localparam int DBG_CORE1    = 1;
  localparam int DBG_CORE0    = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [3:0]       RST_DIR  = 4'h0;
  localparam logic [1:0]       RST_NET  = 2'h0;
  localparam logic [GAP_W-1:0] RST_GAP  = 11'h000;
  localparam logic [31:0]      RST_WORD = 32'h0000_0000;

  // Fixed forwarding register order to link letter (A=0 .. H=7): C D A B G H E F.
  localparam logic [7:0][2:0] FWD_LINK_MAP = {3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};

endpackage
`default_nettype wire

// ===== hdl/link_lane.sv
// Credit, greeting, receiver restart and token pacing for one external link.
`timescale 1ns/100ps
`default_nettype none
module link_lane #(
  parameter int GAP_W = 11
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             enable,
  input  wire logic [GAP_W-1:0] sym_gap,
  input  wire logic [GAP_W-1:0] tok_gap,
  input  wire logic             link_greeting_token_cmd,
  input  wire logic             rxrst_cmd,
  input  wire logic             rx_credit,
  input  wire logic             credit_sent,
  input  wire logic             rx_err,
  input  wire logic             tx_req,
  input  wire logic             tx_first,
  output logic                  tx_go,
  output logic                  credit,
  output logic                  issued,
  output logic                  err,
  output logic                  greet,
  output logic                  rx_restart
);
  typedef struct packed {
    logic             credit;
    logic             issued;
    logic             err;
    logic             go;
    logic             greet;
    logic             restart;
    logic [GAP_W:0]   idle;
  } lane_s;

  lane_s          s_q;
  lane_s          s_d;
  logic [GAP_W:0] gap_now;

  // ==========================================================================
  // Next state: credit set wins over greeting clear, disable clear wins over set; error set wins over restart.
  always_comb begin
    s_d         = s_q;
    s_d.go      = 1'b0;
    s_d.greet   = 1'b0;
    s_d.restart = rxrst_cmd;                               // [R15]
    gap_now     = {1'b0, (tx_first ? tok_gap : sym_gap)};  // [R16] [R17]
    if (s_q.idle != {(GAP_W + 1){1'b1}}) begin
      s_d.idle = s_q.idle + 1'b1;
    end
    if (!enable) begin
      s_d.credit = 1'b0;                                   // [R9]
      s_d.issued = 1'b0;
    end else begin
      if (link_greeting_token_cmd) begin
        s_d.credit = 1'b0;                                 // [R14]
        s_d.greet  = 1'b1;
      end
      if (rx_credit) begin
        s_d.credit = 1'b1;
      end
      if (credit_sent) begin
        s_d.issued = 1'b1;                                 // [R12]
      end
      if (tx_req && s_q.credit && !link_greeting_token_cmd && s_q.idle > gap_now) begin
        s_d.go   = 1'b1;                                   // [R13]
        s_d.idle = '0;
      end
    end
    if (rxrst_cmd) begin
      s_d.err = 1'b0;
    end
    if (rx_err) begin
      s_d.err = 1'b1;                                      // [R11]
    end
  end

  // Register the whole lane state.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_go      = s_q.go;
  assign credit     = s_q.credit;
  assign issued     = s_q.issued;
  assign err        = s_q.err;
  assign greet      = s_q.greet;
  assign rx_restart = s_q.restart;

  // ==========================================================================
  // Checks on credit, greeting, spacing and error capture.
  a_go_has_credit: assert property (@(posedge clk) disable iff (srst)  // [R13]
    tx_go |-> $past(s_q.credit))
    else $error("Token sent without credit.");
  a_link_greeting_token_greets: assert property (@(posedge clk) disable iff (srst)   // [R14]
    (enable && link_greeting_token_cmd && !rx_credit) |=> (greet && !credit))
    else $error("Greeting missing or credit kept.");
  a_token_spacing: assert property (@(posedge clk) disable iff (srst)  // [R17]
    tx_go |-> ($past(s_q.idle) > $past(gap_now)))
    else $error("Idle gap before token too short.");
  a_error_capture: assert property (@(posedge clk) disable iff (srst)  // [R11]
    rx_err |=> err ##1 (err || $past(rxrst_cmd)))
    else $error("Receive error not held.");
endmodule
`default_nettype wire

// ===== hdl/route_select.sv
// Direction lookup for a packet whose destination differs from the node identifier.
`timescale 1ns/100ps
`default_nettype none
module route_select #(
  parameter int ID_W = 16
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [ID_W-1:0]     node_id,
  input  wire logic [ID_W-1:0]     pkt_dest,
  input  wire logic                pkt_valid,
  input  wire logic [ID_W-1:0][3:0] dir_table,
  input  wire logic [7:0][3:0]     link_dir,
  output logic [7:0]               hit
);
  typedef struct packed {
    logic [7:0] hit;
  } route_s;

  route_s          s_q;
  route_s          s_d;
  logic [ID_W-1:0] diff;
  logic [3:0]      dir;
  logic            miss;

  // Pick the direction of the most significant mismatching bit and match links.
  always_comb begin
    s_d  = s_q;
    diff = node_id ^ pkt_dest;
    dir  = 4'h0;
    miss = 1'b0;
    for (int b = 0; b < ID_W; b++) begin
      if (diff[b]) begin
        dir  = dir_table[b];                               // [R21]
        miss = 1'b1;
      end
    end
    if (pkt_valid) begin
      for (int l = 0; l < 8; l++) begin
        s_d.hit[l] = miss && (link_dir[l] == dir);         // [R21]
      end
    end
  end

  // Register the match result.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hit = s_q.hit;

  a_local_no_route: assert property (@(posedge clk) disable iff (srst) // [R21]
    (pkt_valid && pkt_dest == node_id) |=> hit == 8'h00)
    else $error("Local packet was routed.");
endmodule
`default_nettype wire

// ===== hdl/switch_link_control_status.sv
// Register block for link status, link setup, debug origin and fixed forwarding.
`timescale 1ns/100ps
`default_nettype none
module switch_link_control_status #(
  parameter int N = 8
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [9:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [3:0]            byteenable,
  input  wire logic [31:0]           writedata,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  input  wire logic                  dbg_event,
  input  wire logic                  dbg_core,
  input  wire logic [2*N-1:0][1:0]   stat_src_kind,
  input  wire logic [2*N-1:0][7:0]   stat_dest_link,
  input  wire logic [2*N-1:0]        stat_junk,
  input  wire logic [2*N-1:0]        stat_dest_busy,
  input  wire logic [2*N-1:0]        stat_src_busy,
  output logic [2*N-1:0]             pkt_discard,
  output logic [2*N-1:0][1:0]        link_network,
  input  wire logic [N-1:0]          rx_credit,
  input  wire logic [N-1:0]          credit_sent,
  input  wire logic [N-1:0]          rx_err,
  input  wire logic [N-1:0]          tx_req,
  input  wire logic [N-1:0]          tx_first,
  output logic [N-1:0]               tx_go,
  output logic [N-1:0]               link_greeting_token,
  output logic [N-1:0]               rx_restart,
  output logic [N-1:0]               link_enable,
  output logic [N-1:0]               link_five_wire,
  output logic [N-1:0]               fwd_enable,
  output logic [N-1:0]               fwd_core,
  output logic [N-1:0][4:0]          fwd_chan_end,
  input  wire logic [15:0]           node_id,
  input  wire logic [15:0]           pkt_dest,
  input  wire logic                  pkt_valid,
  input  wire logic [15:0][3:0]      dir_table,
  output logic [N-1:0]               route_hit
);
  localparam int GW = link_regs_pkg::GAP_W;

  typedef struct packed {
    logic                  waitreq;
    logic [31:0]           rdata;
    logic [1:0]            resv_a;
    logic [1:0]            resv_b;
    logic                  dbg_resv;
    logic [1:0]            dbg_src;
    logic [N-1:0][3:0]     dir;
    logic [2*N-1:0][1:0]   net;
    logic [2*N-1:0]        discard;
    logic [N-1:0]          en;
    logic [N-1:0]          wide;
    logic [N-1:0][GW-1:0]  sym_gap;
    logic [N-1:0][GW-1:0]  tok_gap;
    logic [N-1:0]          link_greeting_token_p;
    logic [N-1:0]          rxrst_p;
    logic [N-1:0]          fw_en;
    logic [N-1:0]          fw_core;
    logic [N-1:0][4:0]     fw_ch;
  } csr_s;

  csr_s         s_q;
  csr_s         s_d;
  logic [7:0]   idx;
  logic [2:0]   li;
  logic [31:0]  rd_word;
  logic         mapped;
  logic [31:0]  mask;
  logic [31:0]  nw;
  logic         wr_fire;
  logic [N-1:0] ln_credit;
  logic [N-1:0] ln_issued;
  logic [N-1:0] ln_err;

  // Expand the byte enables into a bit mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  assign idx     = address[link_regs_pkg::WORD_LSB +: 8];
  assign li      = idx[2:0];
  assign wr_fire = write && !s_q.waitreq;
  assign mask    = lane_mask(byteenable);
  assign nw      = (rd_word & ~mask) | (writedata & mask);

  // ==========================================================================
  // Read decode; write-only and unused bits stay zero, reserved bits read back their stored value.
  always_comb begin
    rd_word = link_regs_pkg::RST_WORD;                     // [R23]
    mapped  = 1'b1;
    if (idx == link_regs_pkg::IDX_RESV_A) begin
      rd_word[1:0] = s_q.resv_a;
    end else if (idx == link_regs_pkg::IDX_RESV_B) begin
      rd_word[1:0] = s_q.resv_b;
    end else if (idx == link_regs_pkg::IDX_DEBUG) begin
      rd_word[link_regs_pkg::DBG_RESV_BIT] = s_q.dbg_resv;
      rd_word[1:0] = s_q.dbg_src;                          // [R1]
    end else if (idx[7:3] == link_regs_pkg::IDX_EXT_STATE[7:3] ||
                 idx[7:3] == link_regs_pkg::IDX_CORE_STATE[7:3]) begin
      // Entries 0..7 are external links, 8..15 are core links.
      rd_word[link_regs_pkg::SRC_KIND_LSB +: 2] = stat_src_kind[{idx[6], li}];  // [R2] [R8]
      rd_word[link_regs_pkg::DEST_LSB +: 8]     = stat_dest_link[{idx[6], li}]; // [R3]
      rd_word[link_regs_pkg::NET_LSB +: 2]      = s_q.net[{idx[6], li}];        // [R5]
      rd_word[link_regs_pkg::JUNK_BIT]          = stat_junk[{idx[6], li}];      // [R6]
      rd_word[link_regs_pkg::DBUSY_BIT]         = stat_dest_busy[{idx[6], li}]; // [R7]
      rd_word[link_regs_pkg::SBUSY_BIT]         = stat_src_busy[{idx[6], li}];  // [R7]
      if (!idx[6]) begin
        rd_word[link_regs_pkg::DIR_LSB +: 4] = s_q.dir[li];                     // [R4]
      end
    end else if (idx[7:3] == link_regs_pkg::IDX_EXT_SETUP[7:3]) begin
      rd_word[link_regs_pkg::EN_BIT]            = s_q.en[li];
      rd_word[link_regs_pkg::WIDE_BIT]          = s_q.wide[li];
      rd_word[link_regs_pkg::ERR_BIT]           = ln_err[li];                   // [R11]
      rd_word[link_regs_pkg::ISSUED_BIT]        = ln_issued[li];                // [R12]
      rd_word[link_regs_pkg::CREDIT_BIT]        = ln_credit[li];                // [R13]
      rd_word[link_regs_pkg::SYM_GAP_LSB +: GW] = s_q.sym_gap[li];
      rd_word[link_regs_pkg::TOK_GAP_LSB +: GW] = s_q.tok_gap[li];
    end else if (idx[7:3] == link_regs_pkg::IDX_FWD_SETUP[7:3]) begin
      rd_word[link_regs_pkg::FWD_EN_BIT]     = s_q.fw_en[li];
      rd_word[link_regs_pkg::FWD_CORE_BIT]   = s_q.fw_core[li];
      rd_word[link_regs_pkg::FWD_CH_LSB +: 5] = s_q.fw_ch[li];
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================================================
  // Bus handshake, register writes, command pulses and debug capture.
  always_comb begin
    s_d         = s_q;
    s_d.link_greeting_token_p = '0;
    s_d.rxrst_p = '0;
    s_d.discard = stat_junk;                               // [R6]
    if (!s_q.waitreq) begin
      s_d.waitreq = 1'b1;
    end else if (read || write) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = (read && mapped) ? rd_word : link_regs_pkg::RST_WORD;
    end
    if (wr_fire) begin
      if (idx == link_regs_pkg::IDX_RESV_A) begin
        s_d.resv_a = nw[1:0];
      end else if (idx == link_regs_pkg::IDX_RESV_B) begin
        s_d.resv_b = nw[1:0];
      end else if (idx == link_regs_pkg::IDX_DEBUG) begin
        s_d.dbg_resv = nw[link_regs_pkg::DBG_RESV_BIT];
        s_d.dbg_src  = nw[1:0];                            // [R1]
      end else if (idx[7:3] == link_regs_pkg::IDX_EXT_STATE[7:3]) begin
        s_d.dir[li]        = nw[link_regs_pkg::DIR_LSB +: 4];   // [R4]
        s_d.net[{1'b0, li}] = nw[link_regs_pkg::NET_LSB +: 2];  // [R5]
      end else if (idx[7:3] == link_regs_pkg::IDX_CORE_STATE[7:3]) begin
        s_d.net[{1'b1, li}] = nw[link_regs_pkg::NET_LSB +: 2];  // [R8]
      end else if (idx[7:3] == link_regs_pkg::IDX_EXT_SETUP[7:3]) begin
        s_d.en[li]      = nw[link_regs_pkg::EN_BIT];       // [R9]
        s_d.wide[li]    = nw[link_regs_pkg::WIDE_BIT];     // [R10]
        s_d.link_greeting_token_p[li] = nw[link_regs_pkg::LINK_GREETING_TOKEN_BIT];    // [R14] [R22]
        s_d.rxrst_p[li] = nw[link_regs_pkg::RXRST_BIT];    // [R15] [R22]
        s_d.sym_gap[li] = nw[link_regs_pkg::SYM_GAP_LSB +: GW];  // [R16]
        s_d.tok_gap[li] = nw[link_regs_pkg::TOK_GAP_LSB +: GW];  // [R17]
      end else if (idx[7:3] == link_regs_pkg::IDX_FWD_SETUP[7:3]) begin
        s_d.fw_en[li]   = nw[link_regs_pkg::FWD_EN_BIT];   // [R18]
        s_d.fw_core[li] = nw[link_regs_pkg::FWD_CORE_BIT]; // [R19]
        s_d.fw_ch[li]   = nw[link_regs_pkg::FWD_CH_LSB +: 5];  // [R19]
      end
    end
    // A debug event overrides a software write in the same cycle.
    if (dbg_event) begin
      s_d.dbg_src = '0;
      s_d.dbg_src[dbg_core ? link_regs_pkg::DBG_CORE1 : link_regs_pkg::DBG_CORE0] = 1'b1;  // [R1]
    end
  end

  // Register the whole block state.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q         <= '0;
      s_q.waitreq <= 1'b1;
      s_q.dir     <= {N{link_regs_pkg::RST_DIR}};
      s_q.net     <= {(2 * N){link_regs_pkg::RST_NET}};
      s_q.sym_gap <= {N{link_regs_pkg::RST_GAP}};
      s_q.tok_gap <= {N{link_regs_pkg::RST_GAP}};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // One link engine per external link.
  for (genvar g = 0; g < N; g++) begin : g_lane
    link_lane #(
      .GAP_W (GW)
    ) u_lane (
      .clk         (clk),
      .srst        (srst),
      .enable      (s_q.en[g]),
      .sym_gap     (s_q.sym_gap[g]),
      .tok_gap     (s_q.tok_gap[g]),
      .link_greeting_token_cmd   (s_q.link_greeting_token_p[g]),
      .rxrst_cmd   (s_q.rxrst_p[g]),
      .rx_credit   (rx_credit[g]),
      .credit_sent (credit_sent[g]),
      .rx_err      (rx_err[g]),
      .tx_req      (tx_req[g]),
      .tx_first    (tx_first[g]),
      .tx_go       (tx_go[g]),
      .credit      (ln_credit[g]),
      .issued      (ln_issued[g]),
      .err         (ln_err[g]),
      .greet       (link_greeting_token[g]),
      .rx_restart  (rx_restart[g])
    );
    // Fixed forwarding registers land on their link letter.
    assign fwd_enable[link_regs_pkg::FWD_LINK_MAP[g]]   = s_q.fw_en[g];    // [R20]
    assign fwd_core[link_regs_pkg::FWD_LINK_MAP[g]]     = s_q.fw_core[g];  // [R20]
    assign fwd_chan_end[link_regs_pkg::FWD_LINK_MAP[g]] = s_q.fw_ch[g];    // [R20]
  end

  // Direction match for routed packets.
  route_select #(
    .ID_W (16)
  ) u_route (
    .clk       (clk),
    .srst      (srst),
    .node_id   (node_id),
    .pkt_dest  (pkt_dest),
    .pkt_valid (pkt_valid),
    .dir_table (dir_table),
    .link_dir  (s_q.dir),
    .hit       (route_hit)
  );

  // Outputs straight from flip-flops.
  assign readdata       = s_q.rdata;
  assign waitrequest    = s_q.waitreq;
  assign pkt_discard    = s_q.discard;
  assign link_network   = s_q.net;
  assign link_enable    = s_q.en;
  assign link_five_wire = s_q.wide;

  // ==========================================================================
  // Checks on bus timing, writes and captured events.
  sequence s_req_new;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence

  a_bus_answer: assert property (@(posedge clk) disable iff (srst)     // [R23]
    s_req_new |=> s_answer)
    else $error("Bus answer not one cycle.");
  a_dir_write: assert property (@(posedge clk) disable iff (srst)      // [R4]
    (wr_fire && idx[7:3] == link_regs_pkg::IDX_EXT_STATE[7:3] && byteenable[1])
    |=> s_q.dir[$past(li)] == $past(writedata[11:8]))
    else $error("Direction write lost.");
  a_debug_record: assert property (@(posedge clk) disable iff (srst)   // [R1]
    dbg_event |=> s_q.dbg_src == ($past(dbg_core) ? 2'h2 : 2'h1))
    else $error("Debug origin not recorded.");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (srst)  // [R23]
    (read && waitrequest && !mapped) |=> readdata == 32'h0000_0000)
    else $error("Unmapped read not zero.");
  a_link_greeting_token_path: assert property (@(posedge clk) disable iff (srst)     // [R14]
    (wr_fire && idx[7:3] == link_regs_pkg::IDX_EXT_SETUP[7:3] && byteenable[3] &&
     writedata[link_regs_pkg::LINK_GREETING_TOKEN_BIT] && s_q.en[li] && writedata[link_regs_pkg::EN_BIT])
    |=> ##1 link_greeting_token[$past(li, 2)])
    else $error("Greeting not sent after write.");
endmodule
`default_nettype wire

// ===== sim/remote_node.sv
// Remote switch node model that answers each greeting with credit.
`timescale 1ns/100ps
`default_nettype none
module remote_node (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       slow,
  input  wire logic [7:0] greet,
  output logic      [7:0] rx_credit,
  output logic      [7:0] credit_sent
);
  logic [7:0] late_q;
  // ==========================================================================
  // Credit goes back one clock after a greeting, or two when slow.
  always_ff @(posedge clk) begin
    late_q      <= srst ? 8'h00 : greet;
    rx_credit   <= srst ? 8'h00 : (slow ? late_q : greet);
    credit_sent <= srst ? 8'h00 : (slow ? late_q : greet);
  end
endmodule
`default_nettype wire

// ===== sim/tb_switch_link_control_status.sv
// Self-checking bench for the switch link register block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
`define WAIT(c) begin n = 0; while ((c) !== 1'b1 && n < 40) begin @(posedge clk); n++; end \
  `CHK(n < 40, 1'b1) if (n >= 40) report_and_stop(); end
module tb_switch_link_control_status;
  logic clk = 0, srst = 1, read = 0, write = 0, dbg_event = 0, dbg_core = 0, slow = 0;
  logic [9:0] address = 0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 0, readdata, q, d, e;
  logic [7:0] a;
  logic waitrequest, pkt_valid = 0;
  logic [15:0][1:0] stat_src_kind = '0, link_network;
  logic [15:0][7:0] stat_dest_link = '0;
  logic [15:0] stat_junk = 0, stat_dest_busy = 0, stat_src_busy = 0, pkt_discard;
  logic [7:0] rx_credit, credit_sent, rx_err = 0, tx_req = 0, tx_first = 0, tx_go;
  logic [7:0] link_greeting_token, rx_restart, link_enable, link_five_wire;
  logic [7:0] fwd_enable, fwd_core, route_hit;
  logic [7:0][4:0] fwd_chan_end;
  logic [15:0] node_id = 0, pkt_dest = 0;
  logic [15:0][3:0] dir_table = '0;
  logic [7:0][3:0] dirs;
  int fail_count = 0, checks_done = 0, n;
  int lmap [8] = '{2, 3, 0, 1, 6, 7, 4, 5};
  switch_link_control_status #(.N(8)) DUT (.clk, .srst, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .dbg_event, .dbg_core,
    .stat_src_kind, .stat_dest_link, .stat_junk, .stat_dest_busy, .stat_src_busy,
    .pkt_discard, .link_network, .rx_credit, .credit_sent, .rx_err, .tx_req, .tx_first,
    .tx_go, .link_greeting_token, .rx_restart, .link_enable, .link_five_wire, .fwd_enable,
    .fwd_core, .fwd_chan_end, .node_id, .pkt_dest, .pkt_valid, .dir_table, .route_hit);
  remote_node partner (.clk, .srst, .slow, .greet(link_greeting_token), .rx_credit,
    .credit_sent);
  // ==========================================================================
  // Clock of 20 ns period.
  always #10 clk = ~clk;
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Expected matches: links whose direction equals that of the top mismatching id bit.
  function automatic logic [7:0] want_hit(input logic [15:0] id, dst,
                                          input logic [15:0][3:0] tbl,
                                          input logic [7:0][3:0] ld);
    int top;
    top = -1;
    want_hit = 8'h00;
    for (int b = 0; b < 16; b++) begin
      if (id[b] != dst[b]) begin
        top = b;
      end
    end
    for (int l = 0; l < 8; l++) begin
      want_hit[l] = (top >= 0) && (ld[l] == tbl[top[3:0]]);
    end
  endfunction
  // One bus access held until waitrequest is seen low; read data lands in q.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= {idx, 2'b00};
    writedata <= wd;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      fail_count++;
      report_and_stop();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Main sequence: reset values, field layouts, debug origin, credit and restart.
  initial begin
    void'($urandom(49413));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    bus(0, 8'h80, 0); `CHK(q, 32'h0)
    bus(0, 8'hA0, 0); `CHK(q, 32'h0)
    bus(0, 8'h20, 0); `CHK(q, 32'h0)
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      bus(1, 8'(8'hA0 + i), d);
      bus(0, 8'(8'hA0 + i), 0); `CHK(q, d & 32'h8000_011F)
      `CHK({fwd_enable[lmap[i]], fwd_core[lmap[i]], fwd_chan_end[lmap[i]]}, {d[31], d[8], d[4:0]})
    end
    stat_src_kind <= $urandom;
    stat_dest_link <= {4{$urandom()}};
    stat_junk <= $urandom;
    stat_dest_busy <= $urandom;
    stat_src_busy <= $urandom;
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      a = (i < 8) ? 8'(8'h20 + i) : 8'(8'h38 + i);
      bus(1, a, d);
      if (i < 8) dirs[i] = d[11:8];
      bus(0, a, 0);
      e = {6'h00, stat_src_kind[i], stat_dest_link[i], 4'h0, (i < 8) ? d[11:8] : 4'h0,
           2'h0, d[5:4], 1'b0, stat_junk[i], stat_dest_busy[i], stat_src_busy[i]};
      `CHK(q, e)
      `CHK({link_network[i], pkt_discard[i]}, {d[5:4], stat_junk[i]})
    end
    // Routed packets: one local packet, then mismatches with uniform or random tables.
    for (int r = 0; r < 6; r++) begin
      d = $urandom;
      node_id <= d[15:0];
      pkt_dest <= (r == 0) ? d[15:0] : d[31:16];
      dir_table <= r[0] ? {16{dirs[r]}} : {$urandom(), $urandom()};
      pkt_valid <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(route_hit, want_hit(node_id, pkt_dest, dir_table, dirs))
    end
    for (int c = 0; c < 2; c++) begin
      dbg_core <= c[0];
      dbg_event <= 1'b1;
      @(posedge clk);
      dbg_event <= 1'b0;
      bus(0, 8'h1F, 0); `CHK(q[1:0], c ? 2'b10 : 2'b01)
    end
    bus(1, 8'h1F, 32'hFFFF_FFFF);
    bus(0, 8'h1F, 0); `CHK(q, 32'h13)
    bus(1, 8'h10, 32'hFFFF_FFFF);
    bus(0, 8'h10, 0); `CHK(q, 32'h3)
    bus(0, 8'hFF, 0); `CHK(q, 32'h0)
    slow <= 1'b1;
    d = {2'b11, 8'h00, 11'($urandom % 8), 11'($urandom % 8)};
    bus(1, 8'h80, d);
    bus(0, 8'h80, 0); `CHK(q, d)
    `CHK({link_enable[0], link_five_wire[0]}, 2'b11)
    tx_req <= 8'h03;
    bus(1, 8'h80, d | 32'h0100_0000);
    `WAIT(link_greeting_token[0])
    `WAIT(tx_go[0])
    `CHK(tx_go[1], 1'b0)
    // Spacing between sends: symbol gap first, then token gap.
    for (int t = 0; t < 2; t++) begin
      tx_first <= 8'(t);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tx_go[0] !== 1'b1 && n < 40);
      `CHK(n, (t ? d[10:0] : d[21:11]) + 2)
      if (n >= 40) report_and_stop();
    end
    bus(0, 8'h80, 0); `CHK(q, d | 32'h0600_0000)
    rx_err <= 8'h01;
    @(posedge clk);
    rx_err <= 8'h00;
    bus(0, 8'h80, 0); `CHK(q[27], 1'b1)
    bus(1, 8'h80, d | 32'h0080_0000);
    `WAIT(rx_restart[0])
    report_and_stop();
  end
endmodule
`default_nettype wire
